// [sdirq_card_model.sv]
// behavioural card: clocks one response window and answers on the command line
module sdirq_card_model #(
   parameter int CLKS = 8
) (
   input wire logic i_go,
   input wire logic [7:0] i_delay,
   output logic o_clk,
   output logic o_cmd,
   output logic o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_clk = 1'b0;
      o_cmd = 1'b1;
      o_busy = 1'b0;
   end
   // clock stands still outside the window; cmd changes only while the clock is low
   always @(posedge i_go) begin
      o_busy = 1'b1;
      for (int k = 1; k <= CLKS; k++) begin
         o_cmd = (8'(k) >= i_delay) ? 1'b0 : 1'b1;
         #160 o_clk = 1'b1;
         #160 o_clk = 1'b0;
      end
      o_cmd = 1'b1; // released to the pull-up
      o_busy = 1'b0;
   end
endmodule

// [sdirq_pkg.sv]
// shared constants and types for the sd host interrupt enable and auto-stop error block
package sdirq_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SDIRQ_OFS_SIG_EN = 8'h38;
   localparam logic [7:0] SDIRQ_OFS_STOP_ERR = 8'h3C;
   localparam logic [31:0] SDIRQ_SIG_EN_RESET = 32'h0000_0000;
   localparam logic [31:0] SDIRQ_SIG_EN_WMASK = 32'hF1FF_01FF;
   localparam logic [31:0] SDIRQ_STOP_ERR_RESET = 32'h0000_0000;
   localparam logic [1:0] SDIRQ_RESP_OKAY = 2'h0;
   localparam logic [1:0] SDIRQ_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SDIRQ_BIT_STOP_ERR_EN = 24;
   localparam int SDIRQ_BIT_NOT_EXEC = 0;
   localparam int SDIRQ_BIT_TIMEOUT = 1;
   localparam int SDIRQ_BIT_CRC = 2;
   localparam int SDIRQ_BIT_END_BIT = 3;
   localparam int SDIRQ_BIT_INDEX = 4;
   localparam int SDIRQ_BIT_NOT_ISSUED = 7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SDIRQ_RESP_TIMEOUT_CARD_CLKS = 64;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic index_err;
      logic end_bit_err;
      logic crc_err;
   } sdirq_resp_err_t;

   typedef struct packed {
      logic not_issued;
      logic index_err;
      logic end_bit_err;
      logic crc_err;
      logic timeout;
      logic not_exec;
   } sdirq_stop_err_t;
endpackage

// [sdirq_top.sv]
// interrupt signal enable and auto-stop error status registers behind an axi4-lite slave
module sdirq_top
   import sdirq_pkg::*;
#(
   parameter int TIMEOUT_CARD_CLKS = SDIRQ_RESP_TIMEOUT_CARD_CLKS
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // axi4-lite write address and data
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // axi4-lite write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // axi4-lite read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // interrupt status from the status block, error half in 31:16
   input wire logic [31:0] i_irq_status,
   // command engine events
   input wire logic i_stop_issue,
   input wire logic i_stop_blocked,
   input wire logic i_xfer_started,
   input wire logic i_stop_cmd_end,
   input wire logic i_stop_resp_end,
   input wire sdirq_resp_err_t i_stop_resp_err,
   input wire logic i_cmd_pending,
   // card link pins
   input wire logic i_card_clk,
   input wire logic i_card_cmd,
   // outputs to the system
   output logic o_irq,
   output logic o_stop_err
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   // the response counter is eight bits wide
   initial begin
      if (TIMEOUT_CARD_CLKS < 1 || TIMEOUT_CARD_CLKS > 255) begin
         $error("TIMEOUT_CARD_CLKS out of range");
      end
   end

   // ----------------------------------------------------------------
   // card link synchronisers and edge detect
   // ----------------------------------------------------------------
   // the card clock pin is sampled like data: its edges are found on the
   // synchronised copy, so the card clock must stay well below half the
   // system clock or rises are lost
   // the clock pin idles low between frames, so its flops reset low and
   // no false rise follows reset
   logic clk_meta_reg;
   logic clk_sync_reg;
   logic clk_prev_reg;
   logic cmd_meta_reg;
   logic cmd_sync_reg;
   wire card_rise = clk_sync_reg & ~clk_prev_reg;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_meta_reg <= 1'b0;
         clk_sync_reg <= 1'b0;
         clk_prev_reg <= 1'b0;
      end else begin
         clk_meta_reg <= i_card_clk;
         clk_sync_reg <= clk_meta_reg;
         clk_prev_reg <= clk_sync_reg;
      end
   end

   // the cmd line idles high through its pull-up, so its flops reset high
   // and no false start bit is seen after reset
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_meta_reg <= 1'b1;
         cmd_sync_reg <= 1'b1;
      end else begin
         cmd_meta_reg <= i_card_cmd;
         cmd_sync_reg <= cmd_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // auto-stop response timeout
   // ----------------------------------------------------------------
   // the wait opens at the end bit of the stop command and closes at the
   // first start bit or at the timeout; counting only card clock rises keeps
   // the limit in card clock cycles whatever the card clock rate
   // a new command end restarts the count, so a window still open from an old
   // command cannot cut the new timeout short; any low cmd at a rise closes it
   // start bit of the response is a low cmd line seen at a card clock rise
   logic wait_reg;
   logic [7:0] tmo_cnt_reg;
   wire wait_rise = wait_reg & card_rise;
   wire tmo_last = tmo_cnt_reg == 8'(TIMEOUT_CARD_CLKS - 1);
   wire resp_start = wait_rise & ~cmd_sync_reg;
   wire tmo_hit = wait_rise & cmd_sync_reg & tmo_last;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_reg <= 1'b0;
         tmo_cnt_reg <= 8'h00;
      end else if (i_stop_cmd_end) begin
         wait_reg <= 1'b1;
         tmo_cnt_reg <= 8'h00;
      end else if (resp_start || tmo_hit) begin
         wait_reg <= 1'b0;
      end else if (wait_rise) begin
         tmo_cnt_reg <= tmo_cnt_reg + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite handshake
   // ----------------------------------------------------------------
   // address and data are caught independently, in either order, and the
   // write executes once both are held and the last response has gone;
   // ready drops while a half is held so a second item cannot overwrite it
   // the trade is one dead cycle between writes against a two-entry buffer
   // byte strobes are kept with the data so a partial write touches only its bytes
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   wire aw_take = i_awvalid & o_awready;
   wire w_take = i_wvalid & o_wready;
   wire wr_go = aw_held_reg & w_held_reg & ~o_bvalid;
   wire ar_take = i_arvalid & o_arready;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
            o_awready <= 1'b0;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
            o_awready <= 1'b1;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
            o_wready <= 1'b0;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
            o_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // only the low address byte is decoded; the block sits in a 256-byte
   // window and every other word in it answers with an error
   wire wr_en_hit = awaddr_reg == SDIRQ_OFS_SIG_EN;
   wire wr_err_hit = awaddr_reg == SDIRQ_OFS_STOP_ERR;
   wire rd_en_hit = i_araddr == SDIRQ_OFS_SIG_EN;
   wire rd_err_hit = i_araddr == SDIRQ_OFS_STOP_ERR;
   wire [7:0] strb_b0 = {8{wstrb_reg[0]}};
   wire [7:0] strb_b1 = {8{wstrb_reg[1]}};
   wire [7:0] strb_b2 = {8{wstrb_reg[2]}};
   wire [7:0] strb_b3 = {8{wstrb_reg[3]}};
   wire [31:0] strb_mask = {strb_b3, strb_b2, strb_b1, strb_b0};

   // ----------------------------------------------------------------
   // interrupt signal enable register
   // ----------------------------------------------------------------
   logic [31:0] sig_en_reg;
   // the write mask keeps bit 15 and the reserved bits at zero, so they
   // can never reach the interrupt line through a stale enable
   // every enable resets to zero so nothing reaches the line unchosen
   wire [31:0] wr_bits = strb_mask & SDIRQ_SIG_EN_WMASK;
   wire [31:0] sig_en_next = (sig_en_reg & ~wr_bits) | (wdata_reg & wr_bits);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sig_en_reg <= SDIRQ_SIG_EN_RESET;
      end else if (wr_go && wr_en_hit) begin
         sig_en_reg <= sig_en_next;
      end
   end

   // the shared line is registered: one cycle of latency buys a glitch-free
   // output, since the status word changes in many bits at once
   // the flag copy lets the system see the auto-stop error without a bus read
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
         o_stop_err <= 1'b0;
      end else begin
         o_irq <= |(i_irq_status & sig_en_reg);
         o_stop_err <= i_irq_status[SDIRQ_BIT_STOP_ERR_EN];
      end
   end

   // ----------------------------------------------------------------
   // auto-stop error status
   // ----------------------------------------------------------------
   // no bus write reaches this register; engine events and reads of it move it
   sdirq_stop_err_t stop_err_reg;
   sdirq_stop_err_t stop_err_next;
   wire resp_any_err = stop_err_reg.index_err | stop_err_reg.end_bit_err
      | stop_err_reg.crc_err | stop_err_reg.timeout;

   // updates follow the four moments at which the status can change:
   // issue time moves bit 0, the response end bit moves bits 4:1, a timeout
   // moves bits 4:3 and 1, and a read of the register moves bit 7
   // a timeout in the same cycle as a response end wins, since a response
   // that never started cannot carry meaningful error bits
   // bit 7 is evaluated when the read address is taken, because error timing
   // and command writes are not ordered; a pending command counts as not
   // issued only while a response error stands
   always_comb begin
      stop_err_next = stop_err_reg;
      // only a transfer that really started needs the stop command
      if (i_stop_issue && i_xfer_started) begin
         stop_err_next.not_exec = i_stop_blocked;
      end
      if (i_stop_resp_end) begin
         stop_err_next.index_err = i_stop_resp_err.index_err;
         stop_err_next.end_bit_err = i_stop_resp_err.end_bit_err;
         stop_err_next.crc_err = i_stop_resp_err.crc_err;
         stop_err_next.timeout = 1'b0;
      end
      if (tmo_hit) begin
         // crc kept with timeout marks a cmd line conflict
         stop_err_next.timeout = 1'b1;
         stop_err_next.index_err = 1'b0;
         stop_err_next.end_bit_err = 1'b0;
      end
      if (ar_take && rd_err_hit) begin
         stop_err_next.not_issued = i_cmd_pending & resp_any_err;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stop_err_reg <= sdirq_stop_err_t'(6'h00);
      end else begin
         stop_err_reg <= stop_err_next;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // read sees bit 7 freshly evaluated in the same cycle it is sampled;
   // taking the next value also lets an event in that cycle show at once
   // rather than one read later
   wire [31:0] stop_err_word;
   assign stop_err_word[31:8] = 24'h00_0000;
   assign stop_err_word[SDIRQ_BIT_NOT_ISSUED] = stop_err_next.not_issued;
   assign stop_err_word[6:5] = 2'b00;
   assign stop_err_word[SDIRQ_BIT_INDEX] = stop_err_next.index_err;
   assign stop_err_word[SDIRQ_BIT_END_BIT] = stop_err_next.end_bit_err;
   assign stop_err_word[SDIRQ_BIT_CRC] = stop_err_next.crc_err;
   assign stop_err_word[SDIRQ_BIT_TIMEOUT] = stop_err_next.timeout;
   assign stop_err_word[SDIRQ_BIT_NOT_EXEC] = stop_err_next.not_exec;
   wire stop_valid = i_irq_status[SDIRQ_BIT_STOP_ERR_EN];
   // with the flag clear the status word is stale, so it reads as zero
   // rather than showing causes of an error that software never saw
   wire [31:0] rd_en_word = rd_en_hit ? sig_en_reg : 32'h0000_0000;
   wire [31:0] rd_err_word = (rd_err_hit && stop_valid) ? stop_err_word : 32'h0000_0000;
   wire [31:0] rd_word = rd_en_word | rd_err_word;
   wire [1:0] rd_resp = (rd_en_hit || rd_err_hit) ? SDIRQ_RESP_OKAY : SDIRQ_RESP_SLVERR;
   wire [1:0] wr_resp = (wr_en_hit || wr_err_hit) ? SDIRQ_RESP_OKAY : SDIRQ_RESP_SLVERR;

   // a new write response waits for the old one to be taken, and a read
   // is refused while its data still stands, so one of each is under way
   // at most
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bvalid <= 1'b0;
         o_bresp <= SDIRQ_RESP_OKAY;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= SDIRQ_RESP_OKAY;
      end else begin
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_resp;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
         if (ar_take) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_resp;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

endmodule

// [sdirq_top_asserts.sv]
// bus and status checks for sdirq_top
module sdirq_top_asserts
   import sdirq_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid, i_awvalid, i_wvalid, i_bready, i_rready,
   input wire logic [31:0] i_irq_status,
   input wire logic o_arready, o_awready, o_wready, o_bvalid, o_rvalid, o_irq, o_stop_err,
   input wire logic [1:0] o_bresp, o_rresp,
   input wire logic [31:0] o_rdata
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_rd_take;
      i_arvalid && o_arready;
   endsequence
   sequence s_wr_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   a_irq_quiet: assert property (i_irq_status == 32'h0 |=> !o_irq)
      else $error("irq high with no status");
   a_flag_copy: assert property (1'b1 |=> o_stop_err == $past(i_irq_status[24]))
      else $error("stop error flag wrong");
   a_wr_answer: assert property (s_wr_take |=> ##[0:2] o_bvalid)
      else $error("no write response");
   a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   a_rd_answer: assert property (s_rd_take |=> o_rvalid)
      else $error("no read data");
   a_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_ar_block: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   a_stop_masked: assert property (s_rd_take ##0 (i_araddr == 8'h3C && !i_irq_status[24])
      |=> o_rdata == 32'h0)
      else $error("stop status visible without flag");
   a_rd_unmapped: assert property (s_rd_take ##0 (i_araddr != 8'h38 && i_araddr != 8'h3C)
      |=> o_rresp == 2'h2)
      else $error("unmapped read not refused");
endmodule

bind sdirq_top sdirq_top_asserts sdirq_top_asserts_i (.i_clk, .i_nrst, .i_araddr, .i_arvalid,
   .i_awvalid, .i_wvalid, .i_bready, .i_rready, .i_irq_status, .o_arready, .o_awready, .o_wready,
   .o_bvalid, .o_rvalid, .o_irq, .o_stop_err, .o_bresp, .o_rresp, .o_rdata);

// [test_sd_host_irq_enable_autostop_err.sv]
// self-checking bench for the interrupt enable and auto-stop error block
module test_sd_host_irq_enable_autostop_err;
   timeunit 1ns;
   timeprecision 1ns;
   import sdirq_pkg::*;
   localparam int TO = 4;
   logic clk = 0, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, go = 0;
   logic issue = 0, blocked = 0, started = 0, cmd_end = 0, resp_end = 0, pending = 0;
   logic [7:0] awaddr = 0, araddr = 0, delay = 0;
   logic [31:0] wdata = 0, status = 0, rdata;
   sdirq_resp_err_t rerr = '0;
   logic awready, wready, bvalid, arready, rvalid, irq, stop_err, card_clk, card_cmd, busy;
   logic [1:0] bresp, rresp;
   int fail_count = 0, total_checks = 0;
   always #20 clk = ~clk;
   sdirq_top #(.TIMEOUT_CARD_CLKS(TO)) sdirq_top_i (.i_clk(clk), .i_nrst(nrst),
      .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
      .i_wvalid(wv), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arv), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_irq_status(status),
      .i_stop_issue(issue), .i_stop_blocked(blocked), .i_xfer_started(started),
      .i_stop_cmd_end(cmd_end), .i_stop_resp_end(resp_end), .i_stop_resp_err(rerr),
      .i_cmd_pending(pending), .i_card_clk(card_clk), .i_card_cmd(card_cmd), .o_irq(irq),
      .o_stop_err(stop_err));
   sdirq_card_model #(.CLKS(TO + 4)) sdirq_card_model_i (.i_go(go), .i_delay(delay),
      .o_clk(card_clk), .o_cmd(card_cmd), .o_busy(busy));
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic limit(input int n, input int max);
      if (n >= max) begin
         chk("wait", 32'h1, 32'h0);
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      logic ad = 0, wd = 0, bv = 0;
      @(posedge clk);
      {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
      while (!bv && n < 50) begin
         @(posedge clk);
         n++;
         if (!ad && awready) begin ad = 1; awv <= 0; end
         if (!wd && wready) begin wd = 1; wv <= 0; end
         if (ad && wd && bvalid) begin bv = 1; bready <= 0; chk("bresp", 32'(bresp), 32'(r)); end
      end
      limit(n, 50);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n = 0;
      logic ad = 0, rv = 0;
      @(posedge clk);
      {araddr, arv, rready} <= {a, 2'b11};
      while (!rv && n < 50) begin
         @(posedge clk);
         n++;
         if (!ad && arready) begin ad = 1; arv <= 0; end
         else if (ad && rvalid) begin rv = 1; rready <= 0; chk("rdata", rdata, e); end
      end
      chk("rresp", 32'(rresp), 32'(r));
      limit(n, 50);
   endtask
   task automatic stop_issue(input logic b, input logic s);
      @(posedge clk);
      {issue, blocked, started} <= {1'b1, b, s};
      @(posedge clk);
      issue <= 0;
   endtask
   task automatic resp(input logic [2:0] e);
      @(posedge clk);
      {resp_end, rerr} <= {1'b1, e};
      @(posedge clk);
      resp_end <= 0;
   endtask
   task automatic card(input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      cmd_end <= 1;
      @(posedge clk);
      {cmd_end, go, delay} <= {2'b01, d};
      @(posedge clk);
      go <= 0;
      while (busy && n < 200) begin @(posedge clk); n++; end
      limit(n, 200);
      repeat (4) @(posedge clk);
   endtask
   task automatic t_regs();
      status <= 32'h0100_0000;
      rd(8'h38, 32'h0, 2'h0);
      rd(8'h3C, 32'h0, 2'h0);
      wr(8'h38, 32'hFFFF_FFFF, 2'h0);
      rd(8'h38, 32'hF1FF_01FF, 2'h0);
      wr(8'h3C, 32'hFFFF_FFFF, 2'h0);
      rd(8'h3C, 32'h0, 2'h0);
      wr(8'h40, 32'h1, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
   endtask
   task automatic t_irq();
      for (int b = 0; b < 32; b++) begin
         @(posedge clk);
         status <= 32'h1 << b;
         repeat (3) @(posedge clk);
         chk("irq", 32'(irq), (32'hF1FF_01FF >> b) & 32'h1);
      end
      wr(8'h38, 32'h0000_8000, 2'h0);
      status <= 32'hFFFF_FFFF;
      repeat (3) @(posedge clk);
      chk("irq", 32'(irq), 32'h0);
      status <= 32'h0100_0000;
   endtask
   task automatic t_stop();
      stop_issue(1, 1);
      rd(8'h3C, 32'h1, 2'h0);
      stop_issue(0, 1);
      rd(8'h3C, 32'h0, 2'h0);
      stop_issue(1, 0);
      rd(8'h3C, 32'h0, 2'h0);
      for (int i = 0; i < 3; i++) begin
         resp(3'(1 << i));
         rd(8'h3C, 32'h4 << i, 2'h0);
      end
      resp(3'b111);
      pending <= 1;
      rd(8'h3C, 32'h9C, 2'h0);
      pending <= 0;
      rd(8'h3C, 32'h1C, 2'h0);
      status <= 32'h0;
      rd(8'h3C, 32'h0, 2'h0);
      chk("flag", 32'(stop_err), 32'h0);
      status <= 32'h0100_0000;
      card(8'hFF);
      rd(8'h3C, 32'h06, 2'h0);
      chk("flag", 32'(stop_err), 32'h1);
      resp(3'b000);
      rd(8'h3C, 32'h0, 2'h0);
      card(8'(TO - 1));
      rd(8'h3C, 32'h0, 2'h0);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      t_regs();
      t_irq();
      t_stop();
      close_out();
   end
endmodule
